// *** shared/cic_regs.vh ***
// register map, field positions, reset values and timing for the
// command and interrupt control block.
// assumes a 100 MHz system clock and a 32-bit Avalon-MM data path.
`ifndef CIC_REGS_VH
`define CIC_REGS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define CIC_IDX_RSVD 3'h0
`define CIC_IDX_CMD 3'h1
`define CIC_IDX_MEN 3'h2
`define CIC_IDX_AEN 3'h3
`define CIC_IDX_MREQ 3'h4

// ==========================================================
// reset values
`define CIC_RST_RSVD 8'h00
`define CIC_RST_CMD 8'h20
`define CIC_RST_MEN 8'h80
`define CIC_RST_AEN 8'h00
`define CIC_RST_MREQ 8'h14

// ==========================================================
// command control fields
`define CIC_CMD_RCV_OFF 5
`define CIC_CMD_SLEEP 4
`define CIC_CMD_CODE_HI 3
`define CIC_CMD_CODE_LO 0

// main enable and request fields
`define CIC_POLARITY 7
`define CIC_SET_CLEAR 7
`define CIC_TX 6
`define CIC_RX 5
`define CIC_END 4
`define CIC_HIGH 3
`define CIC_LOW 2
`define CIC_FAULT 1
`define CIC_COUNT 0

// aux enable fields
`define CIC_DRIVE_TYPE 7
`define CIC_SECURE 4
`define CIC_CHECKSUM 2
`define CIC_AEN_MASK 8'h94

// ==========================================================
// timing
`define CIC_CLK_NS 10
`define CIC_WAKE_NS 10000

`endif

// *** src/cic_top.v ***
// command control and interrupt gating for a contactless reader front
// end, reached over an Avalon-MM slave with one wait state.
// assumes the command engine, timer, fault and aux request logic sit
// outside and exchange single-cycle pulses or levels on clk_sys.
// every request is answered after exactly one wait state; unmapped
// slots read zero and drop writes, so software never stalls on them.
// the wake-up time is a fixed count of system clocks rather than a
// measured start-up, so software must poll the sleep flag.
// the alert pin is a value plus an enable; the pad and any board
// pull-up sit one level above this block.
// fault is a level input: while it stays high its flag cannot be
// cleared, which matches a fault register that still shows bits.
// the unknown-code fallback and the end flag share one path, so an
// unknown write reports completion exactly like a finished command.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "cic_regs.vh"

module cic_top #(
   parameter IDLE_CODE = 4'h0, // command code that stops activity
   parameter SOFT_CODE = 4'hF, // soft restart command code
   parameter KNOWN_CMDS = 16'h80FF // one bit per accepted code
) (
   input wire clk_sys, // system clock, 100 MHz
   input wire rst, // synchronous reset, active high
   input wire [4:0] avs_address, // byte address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data, low byte used
   output reg [31:0] avs_readdata, // read data, low byte used
   output reg avs_waitrequest, // high while request not yet taken
   input wire cmd_done, // pulse: running command terminated
   input wire ev_tx_done, // pulse: last transmit bit sent
   input wire ev_rx_done, // pulse: valid receive stream ended
   input wire ev_buf_high, // pulse: buffer high alert
   input wire ev_buf_low, // pulse: buffer low alert
   input wire fault_any, // level: any fault register bit set
   input wire ev_countdown_zero, // pulse: timer reached zero
   input wire secure_input_req, // level: secure input activity flag
   input wire checksum_done_req, // level: checksum done flag
   output reg cmd_start, // pulse: command code launched
   output reg [3:0] cmd_code, // code of the running command
   output reg receiver_off, // receiver switched off
   output reg sleep_active, // soft power-down or wake-up in progress
   output reg alert_out, // alert pin output value
   output reg alert_oe // alert pin output enable
);

   // wake-up length in clocks; the counter loads one less than this
   localparam WAKE_CYCLES = `CIC_WAKE_NS / `CIC_CLK_NS;
   localparam [31:0] WAKE_FULL = WAKE_CYCLES - 1;
   localparam [10:0] WAKE_LAST = WAKE_FULL[10:0];
   localparam [10:0] WAKE_ZERO = 11'h000;
   localparam [10:0] WAKE_STEP = 11'h001;

   // reset images kept at register width so fields slice out cleanly
   localparam [7:0] RST_CMD = `CIC_RST_CMD;
   localparam [7:0] RST_MREQ = `CIC_RST_MREQ;

   // ==========================================================
   // register state
   reg receiver_off_flag;
   reg soft_sleep_flag;
   reg waking;
   reg [10:0] wake_cnt;
   reg [7:0] main_irq_enable;
   reg [7:0] aux_irq_enable;
   reg [6:0] main_flags;

   // next-state and combinational helpers
   reg [6:0] next_main_flags;
   reg [7:0] next_readdata;
   reg [3:0] next_code;
   reg next_start;
   reg next_end_flag;
   reg global_req;
   reg pin_level;

   wire [2:0] reg_index;
   wire acc;
   wire wr_acc;
   wire [7:0] wd;
   wire [3:0] wr_code;
   wire soft_active;

   // bus decode: index from the word address, acceptance on acknowledge
   assign reg_index = avs_address[4:2];
   assign acc = (avs_read | avs_write) & ~avs_waitrequest;
   assign wr_acc = avs_write & ~avs_waitrequest;
   assign wd = avs_writedata[7:0];
   assign wr_code = wd[`CIC_CMD_CODE_HI:`CIC_CMD_CODE_LO];
   assign soft_active = (cmd_code == SOFT_CODE);

   // ==========================================================
   // helper functions
   // true when the register index decodes to a write of that slot
   function wr_hit;
      input [2:0] idx;
      input [2:0] slot;
      input we;
      begin
         wr_hit = we & (idx == slot);
      end
   endfunction

   // true when the code is one the command engine accepts
   function known_code;
      input [3:0] code;
      begin
         known_code = KNOWN_CMDS[code];
      end
   endfunction

   // ==========================================================
   // bus handshake: one wait state, then a one-cycle acknowledge
   // readdata loads on the edge that drops waitrequest, so it is settled
   // a full cycle before the master takes it at the next edge
   always @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (avs_waitrequest && (avs_read || avs_write)) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= {24'h00_0000, next_readdata};
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // read mux, reserved bits and write-only selector read zero
   // the mux is sampled at the wait-state edge, so a read shows the
   // state held one cycle before the acknowledge
   always @* begin
      case (reg_index)
         `CIC_IDX_RSVD: next_readdata = `CIC_RST_RSVD;
         `CIC_IDX_CMD: begin
            next_readdata = 8'h00;
            next_readdata[`CIC_CMD_RCV_OFF] = receiver_off_flag;
            // sleep reads one until wake-up completes
            next_readdata[`CIC_CMD_SLEEP] =
               soft_sleep_flag | waking;
            next_readdata[`CIC_CMD_CODE_HI:`CIC_CMD_CODE_LO] =
               cmd_code;
         end
         `CIC_IDX_MEN: next_readdata = main_irq_enable;
         `CIC_IDX_AEN:
            next_readdata = aux_irq_enable & `CIC_AEN_MASK;
         `CIC_IDX_MREQ: next_readdata = {1'b0, main_flags};
         default: next_readdata = 8'h00;
      endcase
   end

   // ==========================================================
   // command field decode on host writes and engine completion
   // a host write beats a completing command for the field in the same
   // cycle; the end of the old command is still reported in the flag
   always @* begin
      next_code = cmd_code;
      next_start = 1'b0;
      next_end_flag = 1'b0;
      if (cmd_done) begin
         // engine finished: fall back to idle, flag only a real command
         next_code = IDLE_CODE;
         next_end_flag = (cmd_code != IDLE_CODE);
      end
      if (wr_hit(reg_index, `CIC_IDX_CMD, wr_acc)) begin
         if (known_code(wr_code)) begin
            next_code = wr_code;
            next_start = 1'b1;
         end else begin
            // unknown code falls back to idle and reports the end
            next_code = IDLE_CODE;
            next_end_flag = 1'b1;
         end
      end
   end

   // command register fields and the sleep sequencer
   // sleep entry is judged against the code running before this write;
   // only a soft restart that is already running refuses the request
   always @(posedge clk_sys) begin
      if (rst) begin
         cmd_code <= RST_CMD[`CIC_CMD_CODE_HI:`CIC_CMD_CODE_LO];
         receiver_off_flag <= RST_CMD[`CIC_CMD_RCV_OFF];
         soft_sleep_flag <= RST_CMD[`CIC_CMD_SLEEP];
         waking <= 1'b0;
         wake_cnt <= WAKE_ZERO;
         cmd_start <= 1'b0;
      end else begin
         cmd_code <= next_code;
         cmd_start <= next_start;
         if (wr_hit(reg_index, `CIC_IDX_CMD, wr_acc)) begin
            // receiver-off is plain storage, sleep needs the sequencer
            receiver_off_flag <= wd[`CIC_CMD_RCV_OFF];
            if (wd[`CIC_CMD_SLEEP]) begin
               // soft restart blocks entry into sleep
               if (!soft_active) begin
                  soft_sleep_flag <= 1'b1;
                  waking <= 1'b0;
               end
            end else if (soft_sleep_flag) begin
               soft_sleep_flag <= 1'b0;
               waking <= 1'b1;
               wake_cnt <= WAKE_LAST;
            end
         end else if (waking) begin
            // count out the wake-up time, then report ready; the flag
            // keeps reading one for the whole count and the final edge
            if (wake_cnt == WAKE_ZERO) begin
               waking <= 1'b0;
            end else begin
               wake_cnt <= wake_cnt - WAKE_STEP;
            end
         end
      end
   end

   // ==========================================================
   // enable registers, aux reserved bits are never stored
   // so a read can never show a stale reserved value
   always @(posedge clk_sys) begin
      if (rst) begin
         main_irq_enable <= `CIC_RST_MEN;
         aux_irq_enable <= `CIC_RST_AEN;
      end else begin
         if (wr_hit(reg_index, `CIC_IDX_MEN, wr_acc)) begin
            main_irq_enable <= wd;
         end
         if (wr_hit(reg_index, `CIC_IDX_AEN, wr_acc)) begin
            aux_irq_enable <= wd & `CIC_AEN_MASK;
         end
      end
   end

   // ==========================================================
   // request flags: host set or clear first, hardware sets win
   // the host update is applied first and the events after it, so an
   // event landing in the same cycle as a clear is kept, never lost
   always @* begin
      next_main_flags = main_flags;
      if (wr_hit(reg_index, `CIC_IDX_MREQ, wr_acc)) begin
         if (wd[`CIC_SET_CLEAR]) begin
            next_main_flags = main_flags | wd[6:0];
         end else begin
            next_main_flags = main_flags & ~wd[6:0];
         end
      end
      // hardware events, each pulse sets its flag, which then holds until the host clears it
      if (ev_tx_done) begin
         next_main_flags[`CIC_TX] = 1'b1;
      end
      if (ev_rx_done) begin
         next_main_flags[`CIC_RX] = 1'b1;
      end
      if (next_end_flag) begin
         next_main_flags[`CIC_END] = 1'b1;
      end
      if (ev_buf_high) begin
         next_main_flags[`CIC_HIGH] = 1'b1;
      end
      if (ev_buf_low) begin
         next_main_flags[`CIC_LOW] = 1'b1;
      end
      // fault is a level and sets its flag again every clock it is high
      if (fault_any) begin
         next_main_flags[`CIC_FAULT] = 1'b1;
      end
      if (ev_countdown_zero) begin
         next_main_flags[`CIC_COUNT] = 1'b1;
      end
   end

   // request flag storage
   always @(posedge clk_sys) begin
      if (rst) begin
         main_flags <= RST_MREQ[`CIC_TX:`CIC_COUNT];
      end else begin
         main_flags <= next_main_flags;
      end
   end

   // ==========================================================
   // global request and pin level before drive selection
   // aux requests are levels held outside in their own register and
   // enter the OR without storage here
   always @* begin
      global_req = (|(main_flags & main_irq_enable[6:0]))
         | (secure_input_req & aux_irq_enable[`CIC_SECURE])
         | (checksum_done_req
            & aux_irq_enable[`CIC_CHECKSUM]);
      pin_level = global_req
         ^ main_irq_enable[`CIC_POLARITY];
   end

   // alert pin drive: push-pull always drives, open drain pulls low
   // open drain never drives high: a high level is left to the pull-up,
   // so the enable carries the inverted level and the value stays low;
   // registering both keeps the pin free of decode glitches
   always @(posedge clk_sys) begin
      if (rst) begin
         alert_out <= 1'b0;
         alert_oe <= 1'b0;
      end else if (aux_irq_enable[`CIC_DRIVE_TYPE]) begin
         alert_out <= pin_level;
         alert_oe <= 1'b1;
      end else begin
         alert_out <= 1'b0;
         alert_oe <= ~pin_level;
      end
   end

   // status outputs for the rest of the front end
   // both lag their source by one clock so every top output is a flop
   always @(posedge clk_sys) begin
      if (rst) begin
         receiver_off <= 1'b0;
         sleep_active <= 1'b0;
      end else begin
         receiver_off <= receiver_off_flag;
         sleep_active <= soft_sleep_flag | waking;
      end
   end

endmodule

// *** verification/cic_alert_host.sv ***
// host side of the alert pin with a board pull-up
// assumes the block drives open drain or push-pull
`timescale 1ns/1ns
module cic_alert_host (
   input wire alert_out, // pin value
   input wire alert_oe, // pin enable
   output wire pin_level // level the host sees
);
   // ====
   // released pin rises to the pull-up level
   assign pin_level = alert_oe ? alert_out : 1'b1;
endmodule

// *** verification/cic_top_assertions.sv ***
// port checks for the command and interrupt control block
// assumes bound to cic_top, one clock, synchronous reset
`timescale 1ns/1ns
module cic_top_assertions #(
   parameter IDLE_CODE = 4'h0, // idle code
   parameter SOFT_CODE = 4'hF, // soft restart code
   parameter KNOWN_CMDS = 16'h80FF // accepted codes
) (
   input wire clk_sys, // clock
   input wire rst, // reset
   input wire [4:0] avs_address, // address
   input wire avs_read, // read
   input wire avs_write, // write
   input wire [31:0] avs_writedata, // write data
   input wire [31:0] avs_readdata, // read data
   input wire avs_waitrequest, // wait
   input wire cmd_start, // launch pulse
   input wire [3:0] cmd_code, // running code
   input wire sleep_active, // sleep state
   input wire alert_out, // pin value
   input wire alert_oe // pin enable
);
   // ====
   // acknowledge decode
   wire [2:0] idx = avs_address[4:2];
   wire rd_ack = avs_read && !avs_waitrequest;
   wire wr_cmd = avs_write && !avs_waitrequest && idx == 3'h1;
   wire [3:0] wcode = avs_writedata[3:0];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ====
   // properties
   rsvd_reads_zero_a: assert property (
      rd_ack && idx == 3'h0 |-> avs_readdata == 32'h0)
      else $error("reserved slot read not zero");
   code_readback_a: assert property (
      rd_ack && idx == 3'h1 |-> avs_readdata[3:0] == $past(cmd_code))
      else $error("command field read differs");
   aux_rsvd_zero_a: assert property (
      rd_ack && idx == 3'h3 |-> (avs_readdata[7:0] & 8'h6B) == 8'h00)
      else $error("aux reserved bits set");
   known_start_a: assert property (
      wr_cmd && KNOWN_CMDS[wcode] |=> cmd_start && cmd_code == $past(wcode))
      else $error("known code not started");
   unknown_idle_a: assert property (
      wr_cmd && !KNOWN_CMDS[wcode] |=> !cmd_start && cmd_code == IDLE_CODE)
      else $error("unknown code not idled");
   sleep_enter_a: assert property (
      wr_cmd && avs_writedata[4] && cmd_code != SOFT_CODE
      |-> ##[1:3] sleep_active) else $error("sleep not entered");
   soft_block_a: assert property (
      wr_cmd && avs_writedata[4] && cmd_code == SOFT_CODE && !sleep_active
      |=> !sleep_active [*3]) else $error("sleep set in restart");
   drain_low_a: assert property (
      alert_out |-> alert_oe) else $error("pin high while released");
   reset_float_a: assert property (
      $fell(rst) |-> !alert_oe && avs_waitrequest)
      else $error("pin driven after reset");
   cover property (wr_cmd && !KNOWN_CMDS[wcode]);
   cover property (sleep_active);
   cover property (alert_oe && alert_out);
endmodule
bind cic_top cic_top_assertions #(.IDLE_CODE(IDLE_CODE),
   .SOFT_CODE(SOFT_CODE), .KNOWN_CMDS(KNOWN_CMDS)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .cmd_start(cmd_start),
   .cmd_code(cmd_code), .sleep_active(sleep_active),
   .alert_out(alert_out), .alert_oe(alert_oe));

// *** verification/cic_top_tb_top.sv ***
// self-checking bench for the command and interrupt control block
// assumes cic_regs.vh on the include path and a pulled-up pin
`timescale 1ns/1ns
`include "cic_regs.vh"
module cic_top_tb_top;
   localparam WAKE = `CIC_WAKE_NS / `CIC_CLK_NS;
   reg clk_sys, rst, rd, wr;
   reg [4:0] adr;
   reg [31:0] wd;
   reg [8:0] ev;
   reg [7:0] q, b;
   wire [31:0] rdata;
   wire [3:0] code;
   wire waitreq, start, rcv_off, sleep, a_out, a_oe, pin;
   integer errors, check_count, i;
   cic_top u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_readdata(rdata), .avs_waitrequest(waitreq),
      .cmd_done(ev[4]), .ev_tx_done(ev[6]), .ev_rx_done(ev[5]),
      .ev_buf_high(ev[3]), .ev_buf_low(ev[2]), .fault_any(ev[1]),
      .ev_countdown_zero(ev[0]), .secure_input_req(ev[7]),
      .checksum_done_req(ev[8]), .cmd_start(start), .cmd_code(code),
      .receiver_off(rcv_off), .sleep_active(sleep), .alert_out(a_out),
      .alert_oe(a_oe));
   cic_alert_host u_host (.alert_out(a_out), .alert_oe(a_oe),
      .pin_level(pin));
   // ====
   // clock and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      errors = errors + 1;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test;
   end
   // ====
   // bus cycle, compare and event tasks
   task bus(input [2:0] x, input w, input [7:0] d);
      begin
         @(posedge clk_sys);
         adr <= {x, 2'b00};
         rd <= !w;
         wr <= w;
         wd <= {24'h0, d};
         @(posedge clk_sys);
         while (waitreq !== 1'b0)
            @(posedge clk_sys);
         q = rdata[7:0];
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask
   task chk(input [7:0] g, input [7:0] e);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   task rchk(input [2:0] x, input [7:0] e);
      begin
         bus(x, 1'b0, 8'h00);
         chk(q, e);
      end
   endtask
   task pchk(input e);
      begin
         repeat (3) @(posedge clk_sys);
         chk({7'h0, pin}, {7'h0, e});
      end
   endtask
   task pulse(input integer k);
      begin
         @(posedge clk_sys);
         ev[k] <= 1'b1;
         @(posedge clk_sys);
         ev[k] <= 1'b0;
      end
   endtask
   task finish_test;
      begin
         if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // ====
   // test sequence
   initial begin
      errors = 0;
      check_count = 0;
      {rst, rd, wr, adr, wd, ev} = {1'b1, 48'h0};
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      pchk(1'b1);
      chk({7'h0, a_oe}, 8'h00);
      for (i = 0; i < 6; i = i + 1)
         rchk(i, 48'h00_14_00_80_20_00 >> (i * 8));
      chk({7'h0, rcv_off}, 8'h01);
      bus(0, 1, 8'hFF);
      rchk(0, 8'h00);
      bus(3, 1, 8'hFF);
      rchk(3, 8'h94);
      bus(4, 1, 8'hFF);
      rchk(4, 8'h7F);
      bus(4, 1, 8'h7F);
      rchk(4, 8'h00);
      bus(3, 1, 8'h00);
      for (i = 0; i < 7; i = i + 1) begin
         pulse(i);
         rchk(4, (i == 4) ? 8'h00 : (8'h01 << i));
         b = 8'h01 << i;
         bus(2, 1, 8'h80 | b);
         rchk(2, 8'h80 | b);
         bus(4, 1, 8'h80 | b);
         pchk(1'b0);
         bus(2, 1, ~b);
         pchk(1'b1);
         bus(2, 1, b);
         pchk(1'b1);
         bus(4, 1, 8'h7F);
         pchk(1'b0);
      end
      bus(3, 1, 8'h80);
      bus(4, 1, 8'hC0);
      pchk(1'b1);
      chk({6'h0, a_oe, a_out}, 8'h03);
      bus(2, 1, 8'h80);
      bus(3, 1, 8'h10);
      ev[7] <= 1'b1;
      pchk(1'b0);
      ev[7] <= 1'b0;
      bus(3, 1, 8'h04);
      ev[8] <= 1'b1;
      pchk(1'b0);
      bus(3, 1, 8'h10);
      pchk(1'b1);
      ev[8] <= 1'b0;
      bus(4, 1, 8'h7F);
      bus(1, 1, 8'h25);
      rchk(1, 8'h25);
      chk({4'h0, code}, 8'h05);
      pulse(4);
      rchk(1, 8'h20);
      rchk(4, 8'h10);
      bus(4, 1, 8'h7F);
      bus(1, 1, 8'h28);
      rchk(1, 8'h20);
      rchk(4, 8'h10);
      bus(4, 1, 8'h7F);
      bus(1, 1, 8'h25);
      bus(1, 1, 8'h20);
      rchk(4, 8'h00);
      bus(1, 1, 8'h2F);
      bus(1, 1, 8'h3F);
      rchk(1, 8'h2F);
      pulse(4);
      bus(1, 1, 8'h30);
      rchk(1, 8'h30);
      chk({7'h0, sleep}, 8'h01);
      bus(1, 1, 8'h20);
      repeat (WAKE - 10) @(posedge clk_sys);
      rchk(1, 8'h30);
      repeat (20) @(posedge clk_sys);
      rchk(1, 8'h20);
      bus(1, 1, 8'h00);
      rchk(1, 8'h00);
      chk({7'h0, rcv_off}, 8'h00);
      finish_test;
   end
endmodule
